// file: sim/tap_probe.sv
`default_nettype none
module tap_probe (
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic test_resetn,
  input wire logic tdo_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    test_resetn = 1'b1;
  end
  // tck rests low between frames
  task automatic clk(input logic m, input logic d, output logic s);
    tms = m;
    tdi = d;
    #80 tck = 1'b1;
    s = tdo_pin;
    #80 tck = 1'b0;
  endtask
  // starts and ends in run-test idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic s;
    dout = 32'h0;
    clk(1'b1, 1'b1, s);
    if (ir) clk(1'b1, 1'b1, s);
    clk(1'b0, 1'b1, s);
    clk(1'b0, 1'b1, s);
    for (int i = 0; i < n; i++) begin
      clk(i == n - 1, din[i], s);
      dout[i] = s;
    end
    clk(1'b1, 1'b1, s);
    clk(1'b0, 1'b1, s);
  endtask
  task automatic tlr;
    logic s;
    repeat (5) clk(1'b1, 1'b1, s);
    clk(1'b0, 1'b1, s);
  endtask
  task automatic trst;
    test_resetn = 1'b0;
    #200 test_resetn = 1'b1;
    #200;
  endtask
endmodule // tap_probe
`default_nettype wire

// file: sim/tap_sva.sv
`default_nettype none
module tap_sva #(
  parameter BS_W = 8
) (
  input wire clock,
  input wire resetn,
  input wire tck,
  input wire test_resetn,
  input wire tdo,
  input wire tdo_oe,
  input wire core_sel,
  input wire [BS_W-1:0] pin_out,
  input wire pin_apply,
  input wire [3:0] tap_state,
  input wire [3:0] instr
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  a_reset_hold: assert property (!test_resetn [*4] |-> tap_state == 4'h0 && !tdo_oe)
    else $error("test reset ignored");
  a_tlr_idcode: assert property (tap_state == 4'h0 [*3] |-> instr == 4'he && !core_sel)
    else $error("idle reset without id instruction");
  a_core_sel: assert property ($stable(instr) |-> core_sel == (instr inside {4'h8, 4'ha, 4'hb}))
    else $error("output select wrong");
  a_apply_dec: assert property ($stable(instr) |-> pin_apply == (instr inside {4'h0, 4'h1}))
    else $error("apply flag wrong");
  a_pin_hold: assert property (pin_apply |-> $stable(pin_out))
    else $error("held pins changed");
  a_oe_shift: assert property (tdo_oe |-> tap_state inside {4'h4, 4'h5, 4'hb, 4'hc})
    else $error("tdo driven outside shift");
  a_tdo_fall: assert property ($changed(tdo) |-> !tck)
    else $error("tdo moved while tck high");
  a_state_rise: assert property ($changed(tap_state) && tap_state != 4'h0 |-> tck)
    else $error("state moved without tck rise");
endmodule // tap_sva
`default_nettype wire

// file: sim/tb_top.sv
`include "tap_defs.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic core_tdo = 1'b1;
  logic [7:0] pin_in = 8'h5a;
  logic [31:0] q;
  int error_cnt = 0;
  int total_checks = 0;
  wire tck, tms, tdi, test_resetn, tdo, tdo_oe, core_sel, pin_apply;
  wire [3:0] tap_state, instr;
  wire [7:0] pin_out;
  // pull-up on the pin when undriven
  wire tdo_pin = tdo_oe ? tdo : 1'b1;
  always #10 clock = ~clock;
  tap_probe tap_probe_i (.tck(tck), .tms(tms), .tdi(tdi), .test_resetn(test_resetn),
    .tdo_pin(tdo_pin));
  jtag_tap_with_tdo_mux jtag_tap_with_tdo_mux_i (.clock(clock), .resetn(resetn),
    .tck(tck), .tms(tms), .tdi(tdi), .test_resetn(test_resetn), .core_tdo(core_tdo),
    .pin_in(pin_in), .tdo(tdo), .tdo_oe(tdo_oe), .core_sel(core_sel), .pin_out(pin_out),
    .pin_apply(pin_apply), .tap_state(tap_state), .instr(instr));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic load(input logic [3:0] op);
    tap_probe_i.scan(1'b1, 4, {28'h0, op}, q);
  endtask
  task automatic t_ident;
    tap_probe_i.scan(1'b0, 32, 32'h0, q);
    chk(q, `TAP_ID_DEFAULT);
    load(`TAP_OP_BYPASS);
    chk(q, {28'h0, `TAP_IR_CAPTURE});
  endtask
  task automatic t_bypass;
    logic [3:0] ops [9] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hc, 4'hd, 4'hf};
    foreach (ops[i]) begin
      load(ops[i]);
      tap_probe_i.scan(1'b0, 3, 32'h3, q);
      chk({27'h0, core_sel, pin_apply, q[2:0]}, 32'h6);
    end
  endtask
  task automatic t_core;
    logic [3:0] ops [3] = '{`TAP_OP_ABORT, `TAP_OP_DEBUG_PORT_ACCESS_INSTR,
                            `TAP_OP_ACCESS_PORT_ACCESS_INSTR};
    @(posedge clock) #2 core_tdo = 1'b0;
    foreach (ops[i]) begin
      load(ops[i]);
      // ones on tdi tell the core path apart from bypass, and core_tdo held low tells it apart from the pull-up
      tap_probe_i.scan(1'b0, 8, 32'hff, q);
      chk({23'h0, core_sel, q[7:0]}, 32'h100);
    end
  endtask
  task automatic t_sample;
    @(posedge clock) #2 core_tdo = 1'b0;
    load(`TAP_OP_SAMPLE);
    tap_probe_i.scan(1'b0, 8, 32'hc3, q);
    chk({q[7:0], pin_out}, 32'h5ac3);
  endtask
  task automatic t_extest;
    logic [3:0] ops [2] = '{`TAP_OP_EXTEST, `TAP_OP_INTEST};
    foreach (ops[i]) begin
      load(ops[i]);
      tap_probe_i.scan(1'b0, 8, 32'h0, q);
      chk({pin_apply, q[7:0], pin_out}, 32'h1ffc3);
    end
  endtask
  task automatic t_treset;
    load(`TAP_OP_BYPASS);
    tap_probe_i.trst;
    chk({tap_state, instr}, 32'h0e);
    tap_probe_i.tlr;
    load(`TAP_OP_BYPASS);
    tap_probe_i.tlr;
    chk({tap_state, instr}, 32'h1e);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clock);
    #2 resetn = 1'b1;
    repeat (8) @(posedge clock);
    #2;
    tap_probe_i.tlr;
    t_ident;
    t_bypass;
    t_core;
    t_sample;
    t_extest;
    t_treset;
    stop_test;
  end
  initial begin
    #400us;
    error_cnt++;
    stop_test;
  end
endmodule // tb_top
bind jtag_tap_with_tdo_mux tap_sva #(.BS_W(BS_W)) tap_sva_i (.clock(clock), .resetn(resetn),
  .tck(tck), .test_resetn(test_resetn), .tdo(tdo), .tdo_oe(tdo_oe), .core_sel(core_sel),
  .pin_out(pin_out), .pin_apply(pin_apply), .tap_state(tap_state), .instr(instr));
`default_nettype wire

// file: src/jtag_tap_with_tdo_mux.v
`include "tap_defs.vh"
`default_nettype none

module jtag_tap_with_tdo_mux #(
  parameter BS_W = `TAP_BS_W,
  parameter [`TAP_ID_W-1:0] ID_VALUE = `TAP_ID_DEFAULT
) (
  input wire clock,
  input wire resetn,
  input wire tck,
  input wire tms,
  input wire tdi,
  input wire test_resetn,
  input wire core_tdo,
  input wire [BS_W-1:0] pin_in,
  output reg tdo,
  output reg tdo_oe,
  output reg core_sel,
  output reg [BS_W-1:0] pin_out,
  output reg pin_apply,
  output reg [3:0] tap_state,
  output reg [`TAP_IR_W-1:0] instr
);

  // --------------------------------------------------
  // controller states
  // --------------------------------------------------
  localparam [3:0] ST_RESET = 4'h0;
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_SEL_DR = 4'h2;
  localparam [3:0] ST_CAP_DR = 4'h3;
  localparam [3:0] ST_SH_DR = 4'h4;
  localparam [3:0] ST_EX1_DR = 4'h5;
  localparam [3:0] ST_PAU_DR = 4'h6;
  localparam [3:0] ST_EX2_DR = 4'h7;
  localparam [3:0] ST_UPD_DR = 4'h8;
  localparam [3:0] ST_SEL_IR = 4'h9;
  localparam [3:0] ST_CAP_IR = 4'ha;
  localparam [3:0] ST_SH_IR = 4'hb;
  localparam [3:0] ST_EX1_IR = 4'hc;
  localparam [3:0] ST_PAU_IR = 4'hd;
  localparam [3:0] ST_EX2_IR = 4'he;
  localparam [3:0] ST_UPD_IR = 4'hf;

  // --------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------
  reg tck_meta, tck_sync, tck_prev;
  reg tms_meta, tms_sync;
  reg tdi_meta, tdi_sync;
  reg trst_meta, trst_sync;
  reg [BS_W-1:0] pin_meta, pin_sync;

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tck_meta <= 1'b0;
      tck_sync <= 1'b0;
      tck_prev <= 1'b0;
      tms_meta <= 1'b1;
      tms_sync <= 1'b1;
      tdi_meta <= 1'b1;
      tdi_sync <= 1'b1;
      trst_meta <= 1'b0;
      trst_sync <= 1'b0;
      pin_meta <= {BS_W{1'b0}};
      pin_sync <= {BS_W{1'b0}};
    end else begin
      tck_meta <= tck;
      tck_sync <= tck_meta;
      tck_prev <= tck_sync;
      tms_meta <= tms;
      tms_sync <= tms_meta;
      tdi_meta <= tdi;
      tdi_sync <= tdi_meta;
      trst_meta <= test_resetn;
      trst_sync <= trst_meta;
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  // tms and tdi share the tck delay, so they stay aligned to the edge
  wire tck_rise = tck_sync & ~tck_prev;
  wire tck_fall = ~tck_sync & tck_prev;

  // --------------------------------------------------
  // next state
  // --------------------------------------------------
  reg [3:0] next_state;

  always @* begin
    case (tap_state)
      ST_RESET: next_state = tms_sync ? ST_RESET : ST_IDLE;
      ST_IDLE: next_state = tms_sync ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: next_state = tms_sync ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: next_state = tms_sync ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: next_state = tms_sync ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: next_state = tms_sync ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: next_state = tms_sync ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: next_state = tms_sync ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: next_state = tms_sync ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: next_state = tms_sync ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: next_state = tms_sync ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: next_state = tms_sync ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: next_state = tms_sync ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: next_state = tms_sync ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: next_state = tms_sync ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: next_state = tms_sync ? ST_SEL_DR : ST_IDLE;
      default: next_state = ST_RESET;
    endcase
  end

  // --------------------------------------------------
  // instruction decode
  // --------------------------------------------------
  reg [`TAP_IR_W-1:0] op;

  always @* begin
    case (instr)
      `TAP_OP_EXTEST,
      `TAP_OP_INTEST,
      `TAP_OP_SAMPLE,
      `TAP_OP_ABORT,
      `TAP_OP_DEBUG_PORT_ACCESS_INSTR,
      `TAP_OP_ACCESS_PORT_ACCESS_INSTR,
      `TAP_OP_IDCODE: op = instr;
      default: op = `TAP_OP_BYPASS;
    endcase
  end

  wire op_core = (op == `TAP_OP_ABORT) | (op == `TAP_OP_DEBUG_PORT_ACCESS_INSTR) |
                 (op == `TAP_OP_ACCESS_PORT_ACCESS_INSTR);
  wire op_apply = (op == `TAP_OP_EXTEST) | (op == `TAP_OP_INTEST);
  wire sel_id = (op == `TAP_OP_IDCODE);
  wire sel_bs = (op == `TAP_OP_SAMPLE);
  // apply instructions keep every data chain still
  wire sel_bypass = ~sel_id & ~sel_bs & ~op_apply;

  // --------------------------------------------------
  // chain strobes
  // --------------------------------------------------
  // one-cycle strobes on a seen tck rise; a stopped tck strobes nothing
  wire step = tck_rise & trst_sync;
  wire cap_ir = step & (tap_state == ST_CAP_IR);
  wire sh_ir = step & (tap_state == ST_SH_IR);
  wire upd_ir = step & (tap_state == ST_UPD_IR);
  wire cap_dr = step & (tap_state == ST_CAP_DR);
  wire sh_dr = step & (tap_state == ST_SH_DR);
  wire upd_dr = step & (tap_state == ST_UPD_DR);

  // --------------------------------------------------
  // controller state
  // --------------------------------------------------
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tap_state <= ST_RESET;
    end else if (!trst_sync) begin
      // held here regardless of tck activity
      tap_state <= ST_RESET;
    end else if (tck_rise) begin
      tap_state <= next_state;
    end
  end

  // --------------------------------------------------
  // instruction chain and holding stage
  // --------------------------------------------------
  reg [`TAP_IR_W-1:0] ir_shift;

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ir_shift <= `TAP_IR_CAPTURE;
    end else if (cap_ir) begin
      ir_shift <= `TAP_IR_CAPTURE;
    end else if (sh_ir) begin
      ir_shift <= {tdi_sync, ir_shift[`TAP_IR_W-1:1]};
    end
  end

  // reload on the way into reset, so the instruction is right
  // for every cycle spent there, even a stay of one tck
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      instr <= `TAP_OP_IDCODE;
    end else if (!trst_sync) begin
      instr <= `TAP_OP_IDCODE;
    end else if (tck_rise && next_state == ST_RESET) begin
      instr <= `TAP_OP_IDCODE;
    end else if (upd_ir) begin
      instr <= ir_shift;
    end
  end

  // --------------------------------------------------
  // bypass chain
  // --------------------------------------------------
  reg bypass_bit;

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bypass_bit <= `TAP_BYPASS_CAPTURE;
    end else if (cap_dr && sel_bypass) begin
      bypass_bit <= `TAP_BYPASS_CAPTURE;
    end else if (sh_dr && sel_bypass) begin
      bypass_bit <= tdi_sync;
    end
  end

  // --------------------------------------------------
  // identification chain
  // --------------------------------------------------
  reg [`TAP_ID_W-1:0] id_shift;

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      id_shift <= {`TAP_ID_W{1'b0}};
    end else if (cap_dr && sel_id) begin
      id_shift <= ID_VALUE;
    end else if (sh_dr && sel_id) begin
      id_shift <= {tdi_sync, id_shift[`TAP_ID_W-1:1]};
    end
  end

  // --------------------------------------------------
  // boundary chain and pin hold stage
  // --------------------------------------------------
  reg [BS_W-1:0] bs_shift;

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bs_shift <= {BS_W{1'b0}};
    end else if (cap_dr && sel_bs) begin
      bs_shift <= pin_sync;
    end else if (sh_dr && sel_bs) begin
      bs_shift <= {tdi_sync, bs_shift[BS_W-1:1]};
    end
  end

  // apply instructions drive the value last loaded by a sample update as it stands
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pin_out <= {BS_W{1'b0}};
    end else if (upd_dr && sel_bs) begin
      pin_out <= bs_shift;
    end
  end

  // --------------------------------------------------
  // output mux and drive
  // --------------------------------------------------
  reg next_tdo;

  always @* begin
    if (tap_state == ST_SH_IR) begin
      next_tdo = ir_shift[0];
    end else if (op_core) begin
      next_tdo = core_tdo;
    end else if (op == `TAP_OP_IDCODE) begin
      next_tdo = id_shift[0];
    end else if (op == `TAP_OP_SAMPLE) begin
      next_tdo = bs_shift[0];
    end else begin
      next_tdo = bypass_bit;
    end
  end

  wire shifting = (tap_state == ST_SH_IR) | ((tap_state == ST_SH_DR) & ~op_apply);

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
      core_sel <= 1'b0;
      pin_apply <= 1'b0;
    end else begin
      core_sel <= op_core;
      pin_apply <= op_apply;
      if (!trst_sync) begin
        tdo_oe <= 1'b0;
      end else if (tck_fall) begin
        tdo <= next_tdo;
        tdo_oe <= shifting;
      end
    end
  end

endmodule // jtag_tap_with_tdo_mux

`default_nettype wire

// file: src/tap_defs.vh
`ifndef TAP_DEFS_VH
`define TAP_DEFS_VH

// --------------------------------------------------
// instruction chain
// --------------------------------------------------
`define TAP_IR_W 4
`define TAP_IR_CAPTURE 4'h1
`define TAP_OP_EXTEST 4'h0
`define TAP_OP_INTEST 4'h1
`define TAP_OP_SAMPLE 4'h2
`define TAP_OP_ABORT 4'h8
`define TAP_OP_DEBUG_PORT_ACCESS_INSTR 4'ha
`define TAP_OP_ACCESS_PORT_ACCESS_INSTR 4'hb
`define TAP_OP_IDCODE 4'he
`define TAP_OP_BYPASS 4'hf

// --------------------------------------------------
// data chains
// --------------------------------------------------
`define TAP_ID_W 32
// identification value is arbitrary
`define TAP_ID_DEFAULT 32'h0000_0001
`define TAP_BS_W 8
`define TAP_BYPASS_CAPTURE 1'b0

`endif
